// file: hw/flash_status_and_array_map.sv
/*
  Status register, command gating and array map of a serial flash.
  Link side runs on the serial clock; commands pass to clk_i on the synchronised
  select rise with the word held stable. Chip select low frames a command.
*/
`timescale 1ns/1ns
module flash_status_and_array_map #(
  parameter int unsigned BUSY_CYCLES = flash_status_pkg::BUSY_TIME_US
                                       * flash_status_pkg::CLK_MHZ
) (
  // System
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Serial link
  input  wire logic        link_clk_i,
  input  wire logic        select_n_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_oe_o,
  // Write-protect pin
  input  wire logic        write_guard_n_i,
  // Status view
  output logic [7:0]       status_o,
  output logic             quad_mode_o,
  output logic             suspended_o,
  output logic [8:0]       last_sector_o,
  output logic [5:0]       last_block32_o,
  output logic [4:0]       last_block64_o,
  output logic             last_protected_o
);

  localparam int unsigned CW = $clog2(BUSY_CYCLES + 1);

  // Link domain: shift in opcode, optional data and address
  logic [5:0]                       bitcnt_r;
  logic [7:0]                       shin_r;
  logic [7:0]                       op_r;
  logic [7:0]                       dat_r;
  logic [flash_status_pkg::ADDR_W-1:0] adr_r;
  flash_status_pkg::cmd_t           cmd_hold_r;
  logic                             frame_done;
  logic                             was_sel_r;
  logic [2:0]                       outbit_r;
  logic [7:0]                       st_link_a_r;
  logic [7:0]                       st_link_r;
  logic                             rd_frame;

  // Framing reset: select high clears the shifter without a link edge
  always_ff @(posedge link_clk_i or posedge select_n_i) begin
    if (select_n_i) begin
      bitcnt_r  <= 6'h00;
      shin_r    <= 8'h00;
      was_sel_r <= 1'b0;
    end else begin
      was_sel_r <= 1'b1;
      shin_r    <= {shin_r[6:0], serial_in_i};
      if (bitcnt_r != 6'h3F) begin
        bitcnt_r <= bitcnt_r + 6'h01;
      end
    end
  end

  // Command word outlives select high so the core can still take it;
  // cleared at the first bit, so a short frame decodes as no command
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_r  <= 8'h00;
      dat_r <= 8'h00;
      adr_r <= '0;
    end else if (!was_sel_r) begin
      op_r  <= 8'h00;
      dat_r <= 8'h00;
      adr_r <= '0;
    end else begin
      if (bitcnt_r == 6'h07) begin
        op_r <= {shin_r[6:0], serial_in_i};
      end
      if (bitcnt_r == 6'h0F) begin
        dat_r <= {shin_r[6:0], serial_in_i};
      end
      if (bitcnt_r >= 6'h08 && bitcnt_r < 6'h20) begin
        adr_r <= {adr_r[flash_status_pkg::ADDR_W-2:0], serial_in_i};
      end
    end
  end

  // Status copy crosses into the link domain through two flops
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_link_a_r <= flash_status_pkg::STATUS_RESET;
      st_link_r   <= flash_status_pkg::STATUS_RESET;
    end else begin
      st_link_a_r <= status_o;
      st_link_r   <= st_link_a_r;
    end
  end

  assign rd_frame = (op_r == flash_status_pkg::OP_ST_READ) && (bitcnt_r >= 6'h08);

  // Output on falling edge; the 3-bit index wraps, so the byte repeats
  always_ff @(negedge link_clk_i or posedge select_n_i) begin
    if (select_n_i) begin
      outbit_r     <= 3'h7;
      serial_out_o <= 1'b0;
      serial_oe_o  <= 1'b0;
    end else if (rd_frame) begin
      serial_out_o <= st_link_r[outbit_r];
      serial_oe_o  <= 1'b1;
      outbit_r     <= outbit_r - 3'h1;
    end else begin
      serial_out_o <= 1'b0;
      serial_oe_o  <= 1'b0;
    end
  end

  // Frame end seen in clk_i domain via synchronised select
  logic sel_meta_r;
  logic sel_sync_r;
  logic sel_last_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_meta_r <= 1'b1;
      sel_sync_r <= 1'b1;
      sel_last_r <= 1'b1;
    end else begin
      sel_meta_r <= select_n_i;
      sel_sync_r <= sel_meta_r;
      sel_last_r <= sel_sync_r;
    end
  end
  assign frame_done = sel_sync_r & ~sel_last_r;

  // New frame marker crosses by toggle, so a frame without bits runs nothing
  logic                                frame_first;
  logic                                frame_seen;
  logic                                fresh_r;
  assign frame_first = ~was_sel_r;
  toggle_sync frame_mark (
    .src_clk_i   (link_clk_i),
    .src_rst_i   (sys_rst_i),
    .src_pulse_i (frame_first),
    .dst_clk_i   (clk_i),
    .dst_rst_i   (sys_rst_i),
    .dst_pulse_o (frame_seen)
  );

  // Core domain: command word is stable while select is high
  logic                                cmd_go_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_hold_r <= '0;
      cmd_go_r   <= 1'b0;
      fresh_r    <= 1'b0;
    end else begin
      cmd_go_r <= frame_done && fresh_r;
      if (frame_seen) begin
        fresh_r <= 1'b1;
      end else if (frame_done) begin
        fresh_r <= 1'b0;
      end
      if (frame_done) begin
        cmd_hold_r <= '{opcode: op_r, data: dat_r, addr: adr_r};
      end
    end
  end

  // Status state
  logic       srp_r;
  logic       qe_r;
  logic [3:0] bp_r;
  logic       wel_r;
  logic       busy_r;
  logic       susp_r;
  logic [CW-1:0] busy_cnt_r;
  flash_status_pkg::op_kind_t kind_r;

  logic [7:0] op;
  logic       allowed_busy;
  logic       is_array_op;
  logic       prot_hit;
  logic       st_locked;
  logic       wg_meta_r;
  logic       wg_sync_r;
  assign op = cmd_hold_r.opcode;
  assign is_array_op = (op == flash_status_pkg::OP_PROG)
                    || (op == flash_status_pkg::OP_SEC_ER)
                    || (op == flash_status_pkg::OP_B32_ER)
                    || (op == flash_status_pkg::OP_B64_ER)
                    || (op == flash_status_pkg::OP_CHIP_ER);
  assign allowed_busy = (op == flash_status_pkg::OP_ST_READ)
                     || (op == flash_status_pkg::OP_FN_READ)
                     || (op == flash_status_pkg::OP_ERP_READ)
                     || (op == flash_status_pkg::OP_RST_EN)
                     || (op == flash_status_pkg::OP_RST)
                     || ((op == flash_status_pkg::OP_SUSPEND)
                         && (kind_r == flash_status_pkg::OPK_ARRAY));
  assign st_locked = srp_r & ~wg_sync_r;

  // Write-protect pin synchroniser
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wg_meta_r <= 1'b1;
      wg_sync_r <= 1'b1;
    end else begin
      wg_meta_r <= write_guard_n_i;
      wg_sync_r <= wg_meta_r;
    end
  end

  // Protected 64K block range from the protect level
  function automatic logic in_prot(input logic [3:0] bp, input logic [4:0] blk);
    logic [4:0] n;
    n = 5'h00;
    in_prot = 1'b0;
    if (bp == flash_status_pkg::BP_NONE || bp == 4'hF) begin
      in_prot = 1'b0;
    end else if (bp >= 4'h6 && bp <= 4'h9) begin
      in_prot = 1'b1;
    end else if (!bp[3]) begin
      n = 5'(5'h1F >> (3'h6 - bp[2:0]));
      in_prot = blk >= (5'h1F - n);
    end else begin
      n = 5'(5'h1F >> (bp[2:0] - 3'h1));
      in_prot = blk <= n;
    end
  endfunction

  // Array map of the command address
  assign prot_hit = in_prot(bp_r, cmd_hold_r.addr[20:flash_status_pkg::B64_SHIFT]);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_sector_o    <= '0;
      last_block32_o   <= '0;
      last_block64_o   <= '0;
      last_protected_o <= 1'b0;
    end else if (cmd_go_r && is_array_op) begin
      last_sector_o    <= cmd_hold_r.addr[20:flash_status_pkg::SECTOR_SHIFT];
      last_block32_o   <= cmd_hold_r.addr[20:flash_status_pkg::B32_SHIFT];
      last_block64_o   <= cmd_hold_r.addr[20:flash_status_pkg::B64_SHIFT];
      last_protected_o <= prot_hit;
    end
  end

  // Command execution and busy timing
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      srp_r      <= 1'b0;
      qe_r       <= 1'b0;
      bp_r       <= flash_status_pkg::BP_NONE;
      wel_r      <= 1'b0;
      busy_r     <= 1'b0;
      susp_r     <= 1'b0;
      busy_cnt_r <= '0;
      kind_r     <= flash_status_pkg::OPK_NONE;
    end else if (busy_r) begin
      if (cmd_go_r && allowed_busy && op == flash_status_pkg::OP_SUSPEND) begin
        susp_r     <= 1'b1;
        busy_r     <= 1'b0;
        kind_r     <= flash_status_pkg::OPK_NONE;
      end else if (busy_cnt_r == CW'(1)) begin
        busy_r <= 1'b0;
        wel_r  <= 1'b0;
        kind_r <= flash_status_pkg::OPK_NONE;
        busy_cnt_r <= '0;
      end else begin
        busy_cnt_r <= busy_cnt_r - CW'(1);
      end
    end else if (cmd_go_r) begin
      case (op)
        flash_status_pkg::OP_PERMIT: wel_r <= 1'b1;
        flash_status_pkg::OP_FORBID: wel_r <= 1'b0;
        flash_status_pkg::OP_ST_WRITE: begin
          if (wel_r && !st_locked) begin
            srp_r      <= cmd_hold_r.data[flash_status_pkg::ST_SRP_BIT];
            qe_r       <= cmd_hold_r.data[flash_status_pkg::ST_QE_BIT];
            bp_r       <= cmd_hold_r.data[flash_status_pkg::ST_BP_HI:flash_status_pkg::ST_BP_LO];
            busy_r     <= 1'b1;
            busy_cnt_r <= CW'(BUSY_CYCLES);
            kind_r     <= flash_status_pkg::OPK_NV_WRITE;
          end
        end
        default: begin
          if (is_array_op && wel_r && !prot_hit
              && !(op == flash_status_pkg::OP_CHIP_ER
                   && bp_r != flash_status_pkg::BP_NONE)) begin
            busy_r     <= 1'b1;
            busy_cnt_r <= CW'(BUSY_CYCLES);
            kind_r     <= flash_status_pkg::OPK_ARRAY;
            susp_r     <= 1'b0;
          end
        end
      endcase
    end
  end

  // Status byte assembly; busy bit reflects only internal state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_o    <= flash_status_pkg::STATUS_RESET;
      quad_mode_o <= 1'b0;
      suspended_o <= 1'b0;
    end else begin
      status_o    <= {srp_r, qe_r, bp_r, wel_r, busy_r};
      quad_mode_o <= qe_r;
      suspended_o <= susp_r;
    end
  end

  a_busy_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy_r && busy_cnt_r == CW'(1) && !(cmd_go_r && op == flash_status_pkg::OP_SUSPEND)
    |=> !busy_r && !wel_r) else $error("busy or latch not cleared at end");
  a_wel_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !busy_r && cmd_go_r && op == flash_status_pkg::OP_ST_WRITE |=> $stable(wel_r))
    else $error("status write altered latch");
  a_lock_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !busy_r && cmd_go_r && st_locked |=> $stable(bp_r) && $stable(srp_r) && $stable(qe_r))
    else $error("locked status changed");
  a_chip_guard: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !busy_r && cmd_go_r && op == flash_status_pkg::OP_CHIP_ER
    && bp_r != flash_status_pkg::BP_NONE |=> !busy_r) else $error("chip erase ran");
  a_busy_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy_r && busy_cnt_r != CW'(1) && cmd_go_r && op == flash_status_pkg::OP_FORBID
    |=> $stable(wel_r) && $stable(bp_r)) else $error("busy accepted write");
  a_status_view: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 status_o[flash_status_pkg::ST_BUSY_BIT] == $past(busy_r))
    else $error("busy bit mismatch");
  a_busy_span: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(busy_r) |-> busy_r[*2]) else $error("busy too short");
  a_qe_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 quad_mode_o == $past(qe_r)) else $error("quad view wrong");

  c_nv_write: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    kind_r == flash_status_pkg::OPK_NV_WRITE);
  c_array_op: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    kind_r == flash_status_pkg::OPK_ARRAY);
  c_suspend: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(susp_r));

endmodule // flash_status_and_array_map

// file: common/flash_status_pkg.sv
/*
  Shared constants and types for the serial flash status register and array map.
  Assumes SPI mode 0/3 single-line command framing and 8-bit opcodes.
*/
package flash_status_pkg;

  // Array organisation
  localparam int unsigned SECTOR_BYTES      = 4096;
  localparam int unsigned SECTORS_PER_B32   = 8;
  localparam int unsigned SECTORS_PER_B64   = 16;
  localparam int unsigned SECTOR_COUNT      = 512;
  localparam logic [23:0] ARRAY_TOP_ADDR    = 24'h1FFFFF;
  localparam int unsigned SECTOR_SHIFT      = 12;
  localparam int unsigned B32_SHIFT         = 15;
  localparam int unsigned B64_SHIFT         = 16;
  localparam int unsigned ADDR_W            = 24;

  // Status byte layout and reset value
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_WEL_BIT    = 1;
  localparam int unsigned ST_BP_LO      = 2;
  localparam int unsigned ST_BP_HI      = 5;
  localparam int unsigned ST_QE_BIT     = 6;
  localparam int unsigned ST_SRP_BIT    = 7;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [3:0]  BP_NONE       = 4'h0;

  // Opcodes
  localparam logic [7:0] OP_PERMIT   = 8'h06;
  localparam logic [7:0] OP_FORBID   = 8'h04;
  localparam logic [7:0] OP_ST_WRITE = 8'h01;
  localparam logic [7:0] OP_ST_READ  = 8'h05;
  localparam logic [7:0] OP_FN_READ  = 8'h48;
  localparam logic [7:0] OP_ERP_READ = 8'h81;
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [7:0] OP_SUSPEND  = 8'h75;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_SEC_ER   = 8'h20;
  localparam logic [7:0] OP_B32_ER   = 8'h52;
  localparam logic [7:0] OP_B64_ER   = 8'hD8;
  localparam logic [7:0] OP_CHIP_ER  = 8'hC7;

  // Model busy time for internal write cycles
  localparam int unsigned BUSY_TIME_US = 100;
  localparam int unsigned CLK_MHZ      = 25;

  typedef struct packed {
    logic       status_protect_flag;
    logic       quad_lines_enable;
    logic [3:0] protect_level;
    logic       write_permit_latch;
    logic       operation_pending_flag;
  } status_byte_t;

  // Decoded command handed from link domain to core domain
  typedef struct packed {
    logic [7:0]        opcode;
    logic [7:0]        data;
    logic [ADDR_W-1:0] addr;
  } cmd_t;

  typedef enum logic [1:0] {
    OPK_NONE,
    OPK_NV_WRITE,
    OPK_ARRAY
  } op_kind_t;

endpackage

// file: hw/toggle_sync.sv
/*
  Event crossing: source toggles a flag, destination resynchronises it over two
  flip-flops and emits one pulse per toggle. Assumes events spaced wider than
  three destination clocks.
*/
`timescale 1ns/1ns
module toggle_sync (
  // Source side
  input  wire logic src_clk_i,
  input  wire logic src_rst_i,
  input  wire logic src_pulse_i,
  // Destination side
  input  wire logic dst_clk_i,
  input  wire logic dst_rst_i,
  output logic      dst_pulse_o
);

  logic tog_r;
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge src_clk_i or posedge src_rst_i) begin
    if (src_rst_i) begin
      tog_r <= 1'b0;
    end else if (src_pulse_i) begin
      tog_r <= ~tog_r;
    end
  end

  always_ff @(posedge dst_clk_i or posedge dst_rst_i) begin
    if (dst_rst_i) begin
      meta_r      <= 1'b0;
      sync_r      <= 1'b0;
      last_r      <= 1'b0;
      dst_pulse_o <= 1'b0;
    end else begin
      meta_r      <= tog_r;
      sync_r      <= meta_r;
      last_r      <= sync_r;
      dst_pulse_o <= sync_r ^ last_r;
    end
  end

endmodule // toggle_sync

// file: test/flash_host_model.sv
/*
  Serial bus master model: mode 0 frames, link clock runs only inside a frame.
  Assumes the device samples on the rising link edge and answers on the falling one.
*/
`timescale 1ns/1ns
module flash_host_model (
  // Link toward the device
  output logic      link_clk_o,
  output logic      select_n_o,
  output logic      serial_data_o,
  // Answer from the device
  input  wire logic serial_in_i,
  input  wire logic serial_oe_i
);
  logic last_r;
  initial begin
    link_clk_o    = 1'b0;
    select_n_o    = 1'b1;
    serial_data_o = 1'b0;
    last_r        = 1'b0;
  end
  // Data line carries no pull, so idle and read phases show a toggling level
  task automatic frame(input logic [31:0] tx, input int n_tx, input int n_rx,
                       output logic [15:0] rx, output logic oe_ok);
    #13;
    select_n_o = 1'b0;
    rx         = 16'h0000;
    oe_ok      = 1'b1;
    for (int i = 0; i < n_tx + n_rx; i++) begin
      serial_data_o = (i < n_tx) ? tx[31 - i] : ~last_r;
      last_r        = serial_data_o;
      #80;
      link_clk_o = 1'b1;
      if (i >= n_tx) begin
        rx    = {rx[14:0], serial_in_i};
        oe_ok = oe_ok & serial_oe_i;
      end
      #80;
      link_clk_o = 1'b0;
    end
    #80;
    select_n_o    = 1'b1;
    serial_data_o = ~last_r;
  endtask
  task automatic send8(input logic [7:0] op);
    logic [15:0] rx;
    logic        ok;
    frame({op, 24'h000000}, 8, 0, rx, ok);
  endtask
  task automatic send16(input logic [7:0] op, input logic [7:0] data);
    logic [15:0] rx;
    logic        ok;
    frame({op, data, 16'h0000}, 16, 0, rx, ok);
  endtask
  task automatic send32(input logic [7:0] op, input logic [23:0] addr);
    logic [15:0] rx;
    logic        ok;
    frame({op, addr}, 32, 0, rx, ok);
  endtask
  // Two copies of the status byte, to see it repeat
  task automatic read_status(output logic [15:0] rx, output logic ok);
    frame({flash_status_pkg::OP_ST_READ, 24'h000000}, 8, 16, rx, ok);
  endtask
endmodule // flash_host_model

// file: test/tb_top.sv
/*
  Self-checking bench for the status register and array map.
  Assumes a shortened busy time so one frame and one status read fit inside it.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned BUSY_N = 400;
  localparam int unsigned LIMIT  = 20000;
  logic        clk_i;
  logic        sys_rst_i;
  logic        write_guard_n_i;
  logic        link_clk;
  logic        select_n;
  logic        serial_in;
  logic        serial_out;
  logic        serial_oe;
  logic [7:0]  status;
  logic        quad_mode;
  logic        suspended;
  logic [8:0]  last_sector;
  logic [5:0]  last_b32;
  logic [4:0]  last_b64;
  logic        last_prot;
  int unsigned n_errors = 0;
  int unsigned checked = 0;
  int unsigned cycles = 0;
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;
  flash_status_and_array_map #(.BUSY_CYCLES(BUSY_N)) dut (
    .clk_i            (clk_i),
    .sys_rst_i        (sys_rst_i),
    .link_clk_i       (link_clk),
    .select_n_i       (select_n),
    .serial_in_i      (serial_in),
    .serial_out_o     (serial_out),
    .serial_oe_o      (serial_oe),
    .write_guard_n_i  (write_guard_n_i),
    .status_o         (status),
    .quad_mode_o      (quad_mode),
    .suspended_o      (suspended),
    .last_sector_o    (last_sector),
    .last_block32_o   (last_b32),
    .last_block64_o   (last_b64),
    .last_protected_o (last_prot)
  );
  flash_host_model host (
    .link_clk_o    (link_clk),
    .select_n_o    (select_n),
    .serial_data_o (serial_in),
    .serial_in_i   (serial_out),
    .serial_oe_i   (serial_oe)
  );
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Covers sync, execution and the select-high spacing
  task automatic gap;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic wait_ready;
    int unsigned n;
    n = 0;
    while (status[0] !== 1'b0 && n < BUSY_N + 100) begin
      @(posedge clk_i);
      n++;
    end
    check(status[0], 1'b0);
    gap();
  endtask
  task automatic permit;
    host.send8(flash_status_pkg::OP_PERMIT);
    gap();
  endtask
  task automatic st_write(input logic [7:0] data);
    permit();
    host.send16(flash_status_pkg::OP_ST_WRITE, data);
    gap();
  endtask
  task automatic rd_check(input logic [7:0] exp);
    logic [15:0] rx;
    logic        ok;
    host.read_status(rx, ok);
    gap();
    check(rx[15:8], exp);
    check(rx[7:0], exp);
    check(ok, 1'b1);
  endtask
  task automatic t_latch;
    check(status, 8'h00);
    check(quad_mode, 1'b0);
    rd_check(8'h00);
    permit();
    check(status, 8'h02);
    host.send8(flash_status_pkg::OP_FORBID);
    gap();
    check(status, 8'h00);
    host.send16(flash_status_pkg::OP_ST_WRITE, 8'hFF);
    gap();
    check(status, 8'h00);
  endtask
  task automatic t_nv_write;
    logic [15:0] rx;
    logic        ok;
    st_write(8'hFF);
    check(status[1:0], 2'h3);
    host.send8(flash_status_pkg::OP_FORBID);
    gap();
    check(status[1:0], 2'h3);
    host.read_status(rx, ok);
    check(rx[8], 1'b1);
    wait_ready();
    check(status, 8'hFC);
    check(quad_mode, 1'b1);
    rd_check(8'hFC);
  endtask
  task automatic t_guard;
    write_guard_n_i <= 1'b0;
    gap();
    st_write(8'h00);
    check(status, 8'hFE);
    write_guard_n_i <= 1'b1;
    gap();
    st_write(8'h3C);
    wait_ready();
    check(status, 8'h3C);
    permit();
    host.send8(flash_status_pkg::OP_CHIP_ER);
    gap();
    check(status, 8'h3E);
    rd_check(8'h3E);
  endtask
  task automatic arr_op(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] sec,
                        input logic [5:0] b32, input logic [4:0] b64);
    permit();
    host.send32(op, addr);
    gap();
    check(status[0], 1'b1);
    check(last_sector, sec);
    check(last_b32, b32);
    check(last_b64, b64);
    check(last_prot, 1'b0);
    wait_ready();
    check(status, 8'h00);
  endtask
  task automatic t_array;
    st_write(8'h00);
    wait_ready();
    arr_op(flash_status_pkg::OP_PROG, 24'h1FFFFF, 9'h1FF, 6'h3F, 5'h1F);
    arr_op(flash_status_pkg::OP_SEC_ER, 24'h000FFF, 9'h000, 6'h00, 5'h00);
    arr_op(flash_status_pkg::OP_B32_ER, 24'h0F0ABC, 9'h0F0, 6'h1E, 5'h0F);
    arr_op(flash_status_pkg::OP_B64_ER, 24'h1EF000, 9'h1EF, 6'h3D, 5'h1E);
    permit();
    host.send8(flash_status_pkg::OP_CHIP_ER);
    gap();
    check(status[0], 1'b1);
    wait_ready();
    st_write(8'h04);
    wait_ready();
    permit();
    host.send32(flash_status_pkg::OP_B64_ER, 24'h1F0000);
    gap();
    check(last_prot, 1'b1);
    check(status, 8'h06);
    host.send32(flash_status_pkg::OP_SEC_ER, 24'h010000);
    gap();
    check(status[0], 1'b1);
    host.send8(flash_status_pkg::OP_SUSPEND);
    gap();
    check(suspended, 1'b1);
    check(status[0], 1'b0);
  endtask
  initial begin
    sys_rst_i       = 1'b1;
    write_guard_n_i = 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_latch();
    t_nv_write();
    t_guard();
    t_array();
    close_out();
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      close_out();
    end
  end
endmodule // tb_top
